// ---- inc/pif_pkg.sv ----
package pif_pkg;

  // device register map, 16-bit addresses on the link
  localparam logic [15:0] DEV_LEVEL_A_ADDR = 16'h5200;
  localparam logic [15:0] DEV_IE_A_ADDR    = 16'h5205;
  localparam logic [15:0] DEV_EDGE_A_ADDR  = 16'h5206;
  localparam logic [15:0] DEV_FLAG_A_ADDR  = 16'h5207;
  localparam logic [15:0] DEV_CHAT_A_ADDR  = 16'h5208;
  localparam logic [15:0] DEV_LEVEL_B_ADDR = 16'h5210;
  localparam logic [15:0] DEV_IE_B_ADDR    = 16'h5215;
  localparam logic [15:0] DEV_EDGE_B_ADDR  = 16'h5216;
  localparam logic [15:0] DEV_FLAG_B_ADDR  = 16'h5217;

  // reset values
  localparam logic [7:0]  DEV_IE_RST       = 8'h00;
  localparam logic [7:0]  DEV_EDGE_RST     = 8'h00;
  localparam logic [7:0]  DEV_FLAG_RST     = 8'h00;
  localparam logic [7:0]  DEV_CHAT_RST     = 8'h00;

  // debounce time register layout
  localparam int          CHAT_LO_POS      = 0;
  localparam int          CHAT_HI_POS      = 4;
  localparam int          CHAT_FLD_W       = 3;
  localparam logic [7:0]  CHAT_WMASK       = 8'h77;
  localparam logic [2:0]  CHAT_OFF         = 3'h0;

  // check time base: code 1 = 256 periods, each code doubles it
  localparam int unsigned FILT_BASE_CYC    = 256;
  localparam int          PRESC_W          = 14;

  // controller APB register map
  localparam logic [11:0] CTL_CTRL_ADDR    = 12'h000;
  localparam logic [11:0] CTL_STAT_ADDR    = 12'h004;
  localparam logic [11:0] CTL_MASK_ADDR    = 12'h008;
  localparam logic [11:0] CTL_BRG_ADDR     = 12'h00C;

  // controller field positions
  localparam int          CTRL_EN_A        = 0;
  localparam int          CTRL_EN_B        = 1;
  localparam int          CTRL_LVL_A       = 2;
  localparam int          CTRL_LVL_B       = 3;
  localparam int          EV_GRP_A         = 0;
  localparam int          EV_GRP_B         = 1;
  localparam int          EV_DONE          = 2;
  localparam int          BRG_WDATA_POS    = 16;
  localparam int          BRG_WE_POS       = 24;
  localparam int          BRG_BUSY_POS     = 8;
  localparam int          BRG_REQ_POS      = 9;
  localparam logic [3:0]  CTL_CTRL_RST     = 4'h0;
  localparam logic [2:0]  CTL_MASK_RST     = 3'h0;

  typedef enum logic [2:0] {
    PIF_IDLE = 3'b001,
    PIF_REQ  = 3'b010,
    PIF_WAIT = 3'b100
  } pif_brg_st_t;

endpackage

// ---- inc/pif_link_if.sv ----
interface pif_link_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  logic [1:0]  irq_req;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata,
    output irq_req
  );

  modport ctl (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata,
    input  irq_req
  );
endinterface

// ---- hw/pif_port_irq.sv ----
// How it works
// - per-pin enable gates flag and request
// - controller group enable needed to reach cpu
// - polarity bit one falling, zero rising
// - one flag per pin, set on edge
// - any group flag raises group request
// - flag reads event; write one clears
// - request holds until flags cleared
// - controller uses level trigger, handler clears
// - software clears flags before enabling
// - group a has two 3-bit nibble fields
// - codes 1-7 give 256..16384 clocks
// - pulses within check time rejected
// - filter stalls in sleep; disable first
// - disable interrupts before changing filter
// - enable registers at 0x5205 and 0x5215
module pif_port_irq
  import pif_pkg::*;
#(
  parameter int unsigned FILT_BASE = FILT_BASE_CYC
)
(
  input  wire logic   CORE_CLK,
  input  wire logic   RESETN,
  input  wire logic [15:0] PIN_IN,
  input  wire logic   SLEEP,
  pif_link_if.dev     LINK
);

  typedef struct packed {
    logic [15:0]        s1;
    logic [15:0]        s2;
    logic [15:0]        filt;
    logic [15:0]        prev;
    logic [15:0]        ie;
    logic [15:0]        edg;
    logic [15:0]        flag;
    logic [7:0]         cand;
    logic [7:0]         chat;
    logic [PRESC_W-1:0] presc;
    logic               ack;
    logic [7:0]         rdata;
  } pif_dev_st_t;

  pif_dev_st_t        r;
  pif_dev_st_t        n;
  logic [1:0]         tick;
  logic [2:0]         code [2];
  logic [15:0]        filt_nxt;
  logic [7:0]         cand_nxt;
  logic [15:0]        hit;
  logic [15:0]        clr;
  logic               wr;
  logic               rd;

  // mask of prescaler bits that must be zero for a check tick
  function automatic logic [PRESC_W-1:0] chk_mask(input logic [2:0] c);
    logic [31:0] per;
    per = 32'h0000_0000;
    if (c != CHAT_OFF)
    begin
      per = FILT_BASE << (c - 3'h1);
    end
    return PRESC_W'(per - 32'h1);
  endfunction

  assign code[0] = r.chat[CHAT_LO_POS +: CHAT_FLD_W];
  assign code[1] = r.chat[CHAT_HI_POS +: CHAT_FLD_W];

  // check ticks per nibble; the prescaler halts in sleep
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_tick
      assign tick[k] = (code[k] != CHAT_OFF) && !SLEEP &&
                       ((r.presc & chk_mask(code[k])) == '0);
    end
  endgenerate

  // per-pin filter on pins 0-7 (pins 8-15 raw) and edge detection on all 16 pins
  generate
    for (genvar i = 0; i < 16; i++)
    begin : g_pin
      logic rise;
      logic fall;
      if (i < 8)
      begin : g_filt
        always_comb
        begin
          cand_nxt[i] = r.cand[i];
          filt_nxt[i] = r.filt[i];
          if (code[i/4] == CHAT_OFF)
          begin
            cand_nxt[i] = r.s2[i];
            filt_nxt[i] = r.s2[i];
          end
          else if (tick[i/4])
          begin
            // level must match on two ticks in a row
            cand_nxt[i] = r.s2[i];
            if (r.s2[i] == r.cand[i])
            begin
              filt_nxt[i] = r.s2[i];
            end
          end
        end
      end
      else
      begin : g_raw
        assign filt_nxt[i] = r.s2[i];
      end
      assign rise   = !r.prev[i] && r.filt[i];
      assign fall   = r.prev[i] && !r.filt[i];
      assign hit[i] = r.ie[i] && (r.edg[i] ? fall : rise);
    end
  endgenerate

  assign wr  = LINK.req && LINK.we;
  assign rd  = LINK.req && !LINK.we;

  // write one clears, per group
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_clr
      assign clr[8*g +: 8] =
        (wr && LINK.addr == ((g == 0) ? DEV_FLAG_A_ADDR : DEV_FLAG_B_ADDR))
          ? LINK.wdata : 8'h00;
    end
  endgenerate

  always_comb
  begin
    n       = r;
    n.s1    = PIN_IN;
    n.s2    = r.s1;
    n.filt  = filt_nxt;
    n.cand  = cand_nxt;
    n.prev  = r.filt;
    if (!SLEEP)
    begin
      n.presc = r.presc + PRESC_W'(1);
    end
    // a new edge wins over a clear in the same cycle
    n.flag  = (r.flag & ~clr) | hit;
    n.ack   = LINK.req;
    n.rdata = 8'h00;
    if (wr)
    begin
      unique case (LINK.addr)
        DEV_IE_A_ADDR:   n.ie[7:0]   = LINK.wdata;
        DEV_IE_B_ADDR:   n.ie[15:8]  = LINK.wdata;
        DEV_EDGE_A_ADDR: n.edg[7:0]  = LINK.wdata;
        DEV_EDGE_B_ADDR: n.edg[15:8] = LINK.wdata;
        DEV_CHAT_A_ADDR: n.chat      = LINK.wdata & CHAT_WMASK;
        default:         n.ie        = n.ie;
      endcase
    end
    // reads answer with ack, one cycle after the request
    if (rd)
    begin
      unique case (LINK.addr)
        DEV_LEVEL_A_ADDR: n.rdata = r.filt[7:0];
        DEV_LEVEL_B_ADDR: n.rdata = r.filt[15:8];
        DEV_IE_A_ADDR:    n.rdata = r.ie[7:0];
        DEV_IE_B_ADDR:    n.rdata = r.ie[15:8];
        DEV_EDGE_A_ADDR:  n.rdata = r.edg[7:0];
        DEV_EDGE_B_ADDR:  n.rdata = r.edg[15:8];
        DEV_FLAG_A_ADDR:  n.rdata = r.flag[7:0];
        DEV_FLAG_B_ADDR:  n.rdata = r.flag[15:8];
        DEV_CHAT_A_ADDR:  n.rdata = r.chat;
        default:          n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      r.s1    <= 16'h0000;
      r.s2    <= 16'h0000;
      r.filt  <= 16'h0000;
      r.prev  <= 16'h0000;
      r.ie    <= {DEV_IE_RST, DEV_IE_RST};
      r.edg   <= {DEV_EDGE_RST, DEV_EDGE_RST};
      r.flag  <= {DEV_FLAG_RST, DEV_FLAG_RST};
      r.cand  <= 8'h00;
      r.chat  <= DEV_CHAT_RST;
      r.presc <= '0;
      r.ack   <= 1'b0;
      r.rdata <= 8'h00;
    end
    else
    begin
      r <= n;
    end
  end

  // level requests follow the flags directly
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_req
      assign LINK.irq_req[g] = |r.flag[8*g +: 8];
    end
  endgenerate
  assign LINK.ack        = r.ack;
  assign LINK.rdata      = r.rdata;

endmodule

// ---- hw/pif_irq_ctl.sv ----
module pif_irq_ctl
  import pif_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             IRQ,
  pif_link_if.ctl          LINK
);

  typedef struct packed {
    pif_brg_st_t st;
    logic [3:0]  ctrl;
    logic [2:0]  pend;
    logic [2:0]  mask;
    logic [1:0]  prev;
    logic        bwe;
    logic [15:0] baddr;
    logic [7:0]  bwdata;
    logic [7:0]  brdata;
    logic [31:0] prdata;
    logic        err;
  } pif_ctl_st_t;

  pif_ctl_st_t r;
  pif_ctl_st_t n;
  logic        acc;
  logic        setup;
  logic [2:0]  set;
  logic [2:0]  w1c;
  logic [1:0]  lvl;

  assign setup = PSEL && !PENABLE;
  assign acc   = PSEL && PENABLE;
  assign lvl   = {r.ctrl[CTRL_LVL_B], r.ctrl[CTRL_LVL_A]};
  assign w1c   = (acc && PWRITE && PADDR == CTL_STAT_ADDR) ? PWDATA[2:0]
                                                           : 3'h0;

  always_comb
  begin
    n    = r;
    set  = 3'h0;
    n.prev = LINK.irq_req;
    // edge mode catches a rising request once
    set[1:0] = LINK.irq_req & ~r.prev;
    set[EV_DONE] = (r.st == PIF_WAIT) && LINK.ack;
    // sticky events: a new event wins over a clear
    n.pend = (r.pend & ~w1c) | set;
    // level mode pending simply mirrors the request line
    for (int g = 0; g < 2; g++)
    begin
      if (lvl[g])
      begin
        n.pend[g] = LINK.irq_req[g];
      end
    end
    unique case (r.st)
      PIF_IDLE:
      begin
        if (acc && PWRITE && PADDR == CTL_BRG_ADDR)
        begin
          n.baddr  = PWDATA[15:0];
          n.bwdata = PWDATA[BRG_WDATA_POS +: 8];
          n.bwe    = PWDATA[BRG_WE_POS];
          n.st     = PIF_REQ;
        end
      end
      PIF_REQ:
      begin
        n.st = PIF_WAIT;
      end
      PIF_WAIT:
      begin
        if (LINK.ack)
        begin
          n.brdata = LINK.rdata;
          n.st     = PIF_IDLE;
        end
      end
      default:
      begin
        n.st = PIF_IDLE;
      end
    endcase
    if (acc && PWRITE && PADDR == CTL_CTRL_ADDR)
    begin
      n.ctrl = PWDATA[3:0];
    end
    if (acc && PWRITE && PADDR == CTL_MASK_ADDR)
    begin
      n.mask = PWDATA[2:0];
    end
    if (setup)
    begin
      n.err    = 1'b0;
      n.prdata = 32'h0000_0000;
      unique case (PADDR)
        CTL_CTRL_ADDR: n.prdata[3:0] = r.ctrl;
        CTL_STAT_ADDR: n.prdata[2:0] = r.pend;
        CTL_MASK_ADDR: n.prdata[2:0] = r.mask;
        CTL_BRG_ADDR:
        begin
          n.prdata[7:0]                = r.brdata;
          n.prdata[BRG_BUSY_POS]       = (r.st != PIF_IDLE);
          n.prdata[BRG_REQ_POS +: 2]   = LINK.irq_req;
        end
        default:       n.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      r.st     <= PIF_IDLE;
      r.ctrl   <= CTL_CTRL_RST;
      r.pend   <= 3'h0;
      r.mask   <= CTL_MASK_RST;
      r.prev   <= 2'h0;
      r.bwe    <= 1'b0;
      r.baddr  <= 16'h0000;
      r.bwdata <= 8'h00;
      r.brdata <= 8'h00;
      r.prdata <= 32'h0000_0000;
      r.err    <= 1'b0;
    end
    else
    begin
      r <= n;
    end
  end

  assign PREADY     = 1'b1;
  assign PRDATA     = r.prdata;
  assign PSLVERR    = acc && r.err;
  assign LINK.req   = (r.st == PIF_REQ);
  assign LINK.we    = r.bwe;
  assign LINK.addr  = r.baddr;
  assign LINK.wdata = r.bwdata;
  // group enables gate the group events onto the line
  assign IRQ = |(r.pend & r.mask &
                 {1'b1, r.ctrl[CTRL_EN_B], r.ctrl[CTRL_EN_A]});

endmodule

// ---- verification/pif_link_monitor.sv ----
module pif_link_monitor
  import pif_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        RESETN,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic [7:0]  rdata,
  input wire logic [1:0]  irq_req
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);

  ack_follow_a:
    assert property (req |=> ack)
    else $error("ack missing after req");
  ack_cause_a:
    assert property (ack |-> $past(req))
    else $error("ack without req");
  req_pulse_a:
    assert property (req |=> !req [*2])
    else $error("req not a lone pulse");
  req_hold_a:
    assert property (req |=> $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link command changed early");
  wr_rdata_zero_a:
    assert property (ack && $past(we) |-> rdata == 8'h00)
    else $error("write answered with data");
  chat_rsvd_a:
    assert property (ack && !$past(we) && $past(addr) == DEV_CHAT_A_ADDR
                     |-> !rdata[7] && !rdata[3])
    else $error("debounce reserved bit set");
  clr_grp_a_a:
    assert property ($fell(irq_req[0])
                     |-> we && addr == DEV_FLAG_A_ADDR && wdata != 8'h00)
    else $error("group a request dropped without clear");
  clr_grp_b_a:
    assert property ($fell(irq_req[1])
                     |-> we && addr == DEV_FLAG_B_ADDR && wdata != 8'h00)
    else $error("group b request dropped without clear");
endmodule

// ---- verification/test_port_input_interrupt_filter.sv ----
module test_port_input_interrupt_filter
  import pif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TB_FILT = 4;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        pen = 0;
  logic        pwr = 0;
  logic        sleep = 0;
  logic        e;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic [15:0] pins = 0;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          t;
  pif_link_if  link ();

  always #20 clk = ~clk;

  pif_port_irq #(.FILT_BASE(TB_FILT)) i_pif_port_irq (
    .CORE_CLK(clk), .RESETN(rst_n), .PIN_IN(pins), .SLEEP(sleep),
    .LINK(link));
  pif_irq_ctl i_pif_irq_ctl (
    .CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINK(link));
  pif_link_monitor i_pif_link_monitor (
    .CORE_CLK(clk), .RESETN(rst_n), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .irq_req(link.irq_req));

  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // one device access through the bridge, polled until idle
  task dv(input logic w, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, CTL_BRG_ADDR, {7'h00, w, d, a});
    do apb(1'b0, CTL_BRG_ADDR, 32'h0000_0000);
    while (r[BRG_BUSY_POS] !== 1'b0);
  endtask

  task rdc(input string n, input logic [15:0] a, input logic [7:0] x);
    dv(1'b0, a, 8'h00);
    chk(n, {24'h00_0000, x}, {24'h00_0000, r[7:0]});
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      test_done;
    end
  end

  initial
  begin
    logic [15:0] ra [7];
    ra = '{DEV_IE_A_ADDR, DEV_EDGE_A_ADDR, DEV_FLAG_A_ADDR, DEV_CHAT_A_ADDR,
           DEV_IE_B_ADDR, DEV_EDGE_B_ADDR, DEV_FLAG_B_ADDR};
    cyc(20);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc("reset", ra[i], 8'h00);
    apb(1'b0, CTL_MASK_ADDR, 32'h0000_0000);
    chk("mask", 32'h0000_0000, r);
    apb(1'b0, 12'h010, 32'hFFFF_FFFF);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
    rdc("dev_unmap", 16'h5201, 8'h00);
    apb(1'b0, CTL_STAT_ADDR, 32'h0000_0000);
    chk("done", 32'h0000_0001, {31'h0000_0000, r[EV_DONE]});
    apb(1'b1, CTL_STAT_ADDR, 32'h0000_0004);
    apb(1'b0, CTL_STAT_ADDR, 32'h0000_0000);
    chk("done_clr", 32'h0000_0000, {31'h0000_0000, r[EV_DONE]});
    // pins toggled while disabled
    pins <= 16'h00FF;
    cyc(8);
    pins <= 16'h0000;
    cyc(8);
    rdc("off_a", DEV_FLAG_A_ADDR, 8'h00);
    dv(1'b1, DEV_FLAG_A_ADDR, 8'hFF);
    dv(1'b1, DEV_FLAG_B_ADDR, 8'hFF);
    dv(1'b1, DEV_IE_A_ADDR, 8'hFF);
    dv(1'b1, DEV_IE_B_ADDR, 8'hFF);
    rdc("ie_b", DEV_IE_B_ADDR, 8'hFF);
    dv(1'b1, DEV_EDGE_A_ADDR, 8'h02);
    rdc("edge_a", DEV_EDGE_A_ADDR, 8'h02);
    pins <= 16'h0003;
    cyc(8);
    rdc("rise", DEV_FLAG_A_ADDR, 8'h01);
    pins <= 16'h0000;
    cyc(8);
    rdc("fall", DEV_FLAG_A_ADDR, 8'h03);
    dv(1'b1, DEV_FLAG_A_ADDR, 8'h00);
    rdc("w0", DEV_FLAG_A_ADDR, 8'h03);
    dv(1'b1, DEV_FLAG_A_ADDR, 8'h03);
    rdc("w1", DEV_FLAG_A_ADDR, 8'h00);
    // edge mode keeps group a pending after the flags are gone
    apb(1'b0, CTL_STAT_ADDR, 32'h0000_0000);
    chk("edge_pend", 32'h0000_0001, {31'h0000_0000, r[EV_GRP_A]});
    apb(1'b1, CTL_STAT_ADDR, 32'h0000_0001);
    apb(1'b0, CTL_STAT_ADDR, 32'h0000_0000);
    chk("edge_clr", 32'h0000_0000, {31'h0000_0000, r[EV_GRP_A]});
    // group b through the controller, level mode
    apb(1'b1, CTL_CTRL_ADDR, 32'h0000_000F);
    apb(1'b1, CTL_MASK_ADDR, 32'h0000_0003);
    pins <= 16'hFF00;
    cyc(8);
    rdc("flag_b", DEV_FLAG_B_ADDR, 8'hFF);
    rdc("level_b", DEV_LEVEL_B_ADDR, 8'hFF);
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    apb(1'b0, CTL_STAT_ADDR, 32'h0000_0000);
    chk("stat_b", 32'h0000_0001, {31'h0000_0000, r[EV_GRP_B]});
    apb(1'b1, CTL_MASK_ADDR, 32'h0000_0001);
    cyc(1);
    chk("irq_mask", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, CTL_MASK_ADDR, 32'h0000_0003);
    apb(1'b1, CTL_CTRL_ADDR, 32'h0000_000D);
    cyc(1);
    chk("irq_en", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, CTL_CTRL_ADDR, 32'h0000_000F);
    dv(1'b1, DEV_FLAG_B_ADDR, 8'h0F);
    rdc("part_clr", DEV_FLAG_B_ADDR, 8'hF0);
    chk("irq_hold", 32'h0000_0001, {31'h0000_0000, irq});
    dv(1'b1, DEV_FLAG_B_ADDR, 8'hF0);
    cyc(1);
    chk("irq_drop", 32'h0000_0000, {31'h0000_0000, irq});
    pins <= 16'h0000;
    cyc(8);
    // nibble split of the debounce fields
    dv(1'b1, DEV_IE_A_ADDR, 8'h00);
    dv(1'b1, DEV_CHAT_A_ADDR, 8'hFF);
    rdc("chat", DEV_CHAT_A_ADDR, 8'h77);
    dv(1'b1, DEV_CHAT_A_ADDR, 8'h10);
    dv(1'b1, DEV_IE_A_ADDR, 8'hFF);
    pins <= 16'h0018;
    cyc(1);
    pins <= 16'h0000;
    cyc(12);
    rdc("nibble", DEV_FLAG_A_ADDR, 8'h08);
    dv(1'b1, DEV_FLAG_A_ADDR, 8'h08);
    // every check time code on the low nibble
    for (int c = 1; c < 8; c++)
    begin
      t = TB_FILT << (c - 1);
      dv(1'b1, DEV_IE_A_ADDR, 8'h00);
      dv(1'b1, DEV_CHAT_A_ADDR, 8'(c));
      dv(1'b1, DEV_FLAG_A_ADDR, 8'hFF);
      dv(1'b1, DEV_IE_A_ADDR, 8'hFF);
      pins <= 16'h0004;
      cyc(t - 1);
      pins <= 16'h0000;
      cyc(2 * t + 8);
      rdc("short", DEV_FLAG_A_ADDR, 8'h00);
      pins <= 16'h0004;
      cyc(2 * t + 8);
      rdc("long", DEV_FLAG_A_ADDR, 8'h04);
      pins <= 16'h0000;
      cyc(2 * t + 8);
      dv(1'b1, DEV_FLAG_A_ADDR, 8'h04);
    end
    // filter frozen while asleep
    dv(1'b1, DEV_CHAT_A_ADDR, 8'h01);
    sleep <= 1'b1;
    pins <= 16'h0004;
    cyc(40);
    rdc("sleep", DEV_FLAG_A_ADDR, 8'h00);
    sleep <= 1'b0;
    cyc(20);
    rdc("wake", DEV_FLAG_A_ADDR, 8'h04);
    dv(1'b1, DEV_CHAT_A_ADDR, 8'h00);
    test_done;
  end
endmodule
